// ---- core/stats_counters.sv ----
/*
 * Receive and transmit frame statistics counters with snapshot readout.
 * Counters are fed by per-frame status events and read only through the
 * statistics readout request, one 32-bit word at a time. Assumes the status
 * paths and the request reader sit on ref_clk_i.
 */
module stats_counters
    import stats_pkg::*;
#(
    parameter int LEN_W = 14
) (
    // Clock and reset.
    input  wire logic             ref_clk_i,
    input  wire logic             srst_i,
    // Receive status from the MAC and the rx_fifo_flow_controller.
    input  wire logic             rx_stat_vld_i,
    input  wire logic             rx_crc_err_i,
    input  wire logic             rx_dribble_i,
    input  wire logic             rx_late_col_i,
    input  wire logic             rx_phy_err_i,
    input  wire logic             rx_fifo_drop_i,
    input  wire logic [LEN_W-1:0] rx_len_i,
    input  wire logic [LEN_W-1:0] max_len_i,
    // Transmit status from the MAC.
    input  wire logic             tx_stat_vld_i,
    input  wire logic             tx_pause_i,
    input  wire logic [4:0]       tx_col_cnt_i,
    input  wire logic             tx_excess_col_i,
    input  wire logic             tx_late_col_i,
    input  wire logic             tx_underrun_i,
    input  wire logic             tx_excess_defer_i,
    input  wire logic             tx_carrier_err_i,
    // Readout request from the usb_control_unit.
    input  wire logic             req_vld_i,
    input  wire logic [15:0]      req_index_i,
    input  wire logic [15:0]      req_length_i,
    // Readout answer.
    input  wire logic             rsp_ready_i,
    output logic                  rsp_vld_o,
    output logic [CNT_W-1:0]      rsp_data_o,
    output logic                  rsp_last_o,
    output logic                  rsp_stall_o,
    output logic                  busy_o
);

    stats_if ev ();

    logic [CNT_W-1:0] rx_cnt_q [RX_CNTS];
    logic [CNT_W-1:0] tx_cnt_q [TX_CNTS];

    rd_state_e        state_q, state_d;
    logic [PTR_W-1:0] ptr_q, ptr_d;
    logic [PTR_W-1:0] last_q, last_d;
    logic             busy_q, busy_d;
    logic             vld_q, vld_d;
    logic             rlast_q, rlast_d;
    logic             stall_q, stall_d;
    logic [CNT_W-1:0] data_q, data_d;

    logic             sel_rx, sel_tx, req_ok, take, refuse, acc;

    // Adds one and wraps at the counter's own width, so a short counter
    // rolls from all ones to zero instead of spilling into the upper bits.
    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v,
                                              input logic             wide);
        logic [SHORT_W-1:0] s;
        s = v[SHORT_W-1:0] + SHORT_W'(1);
        if (wide) begin
            bump = v + CNT_W'(1);
        end else begin
            bump = {{(CNT_W-SHORT_W){1'b0}}, s};
        end
    endfunction

    // Event classification lives in its own module.
    stats_event_decode #(
        .LEN_W (LEN_W)
    ) u_decode (
        .rx_stat_vld_i     (rx_stat_vld_i),
        .rx_crc_err_i      (rx_crc_err_i),
        .rx_dribble_i      (rx_dribble_i),
        .rx_late_col_i     (rx_late_col_i),
        .rx_phy_err_i      (rx_phy_err_i),
        .rx_fifo_drop_i    (rx_fifo_drop_i),
        .rx_len_i          (rx_len_i),
        .max_len_i         (max_len_i),
        .tx_stat_vld_i     (tx_stat_vld_i),
        .tx_pause_i        (tx_pause_i),
        .tx_col_cnt_i      (tx_col_cnt_i),
        .tx_excess_col_i   (tx_excess_col_i),
        .tx_late_col_i     (tx_late_col_i),
        .tx_underrun_i     (tx_underrun_i),
        .tx_excess_defer_i (tx_excess_defer_i),
        .tx_carrier_err_i  (tx_carrier_err_i),
        .ev                (ev.dec)
    );

    // Snapshot store that the readout walks through.
    stats_snap_mem u_snap (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .sm        (ev.mem)
    );

    // Receive counters; readout never writes here, only events do.
    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < RX_CNTS; i++) begin
            if (srst_i) begin
                rx_cnt_q[i] <= '0;
            end else if (ev.rx_inc[i]) begin
                rx_cnt_q[i] <= bump(rx_cnt_q[i], RX_WIDE[i]);
            end
        end
    end

    // Transmit counters, same wrap behaviour as the receive side.
    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < TX_CNTS; i++) begin
            if (srst_i) begin
                tx_cnt_q[i] <= '0;
            end else if (ev.tx_inc[i]) begin
                tx_cnt_q[i] <= bump(tx_cnt_q[i], TX_WIDE[i]);
            end
        end
    end

    // Request check: the selector picks the set and the length must match
    // that set exactly; anything else arriving while idle is answered with a stall.
    assign sel_rx = (req_index_i == SEL_RX);
    assign sel_tx = (req_index_i == SEL_TX);
    assign req_ok = (sel_rx && req_length_i == LEN_RX)
                 || (sel_tx && req_length_i == LEN_TX);
    assign take   = req_vld_i && !busy_q && req_ok;
    assign refuse = req_vld_i && !busy_q && !req_ok;
    assign acc    = vld_q && rsp_ready_i;

    // Snapshot image of the selected set. Events landing in the take cycle
    // show up in the next readout, never half in this one.
    always_comb begin
        for (int w = 0; w < SNAP_WORDS; w++) begin
            ev.load_data[w] = '0;
        end
        for (int w = 0; w < TX_CNTS; w++) begin
            if (sel_tx) begin
                ev.load_data[w] = tx_cnt_q[w];
            end
        end
        for (int w = 0; w < RX_CNTS; w++) begin
            if (sel_rx) begin
                ev.load_data[w] = rx_cnt_q[w];
            end
        end
    end

    // Memory controls: one load per accepted request, reads in the fetch state.
    assign ev.load    = take;
    assign ev.rd_en   = (state_q == ST_FETCH);
    assign ev.rd_addr = ptr_q;

    // Readout sequencer: fetch a word, show it, hold it until accepted.
    // Three cycles per word is slow but far faster than the control pipe.
    always_comb begin
        state_d = state_q;
        ptr_d   = ptr_q;
        last_d  = last_q;
        busy_d  = busy_q;
        vld_d   = vld_q;
        rlast_d = rlast_q;
        stall_d = refuse;
        data_d  = data_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_FETCH;
                    ptr_d   = '0;
                    last_d  = sel_tx ? TX_LAST : RX_LAST;
                    busy_d  = 1'b1;
                end
            end
            ST_FETCH: begin
                state_d = ST_SHOW;
            end
            ST_SHOW: begin
                state_d = ST_SEND;
                vld_d   = 1'b1;
                data_d  = ev.rd_data;
                rlast_d = (ptr_q == last_q);
            end
            ST_SEND: begin
                if (acc) begin
                    vld_d   = 1'b0;
                    rlast_d = 1'b0;
                    if (rlast_q) begin
                        state_d = ST_IDLE;
                        busy_d  = 1'b0;
                    end else begin
                        state_d = ST_FETCH;
                        ptr_d   = ptr_q + PTR_W'(1);
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
                busy_d  = 1'b0;
                vld_d   = 1'b0;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q <= ST_IDLE;
            ptr_q   <= '0;
            last_q  <= '0;
            busy_q  <= 1'b0;
            vld_q   <= 1'b0;
            rlast_q <= 1'b0;
            stall_q <= 1'b0;
            data_q  <= '0;
        end else begin
            state_q <= state_d;
            ptr_q   <= ptr_d;
            last_q  <= last_d;
            busy_q  <= busy_d;
            vld_q   <= vld_d;
            rlast_q <= rlast_d;
            stall_q <= stall_d;
            data_q  <= data_d;
        end
    end

    // Outputs come straight from the sequencer flops.
    assign rsp_vld_o   = vld_q;
    assign rsp_data_o  = data_q;
    assign rsp_last_o  = rlast_q;
    assign rsp_stall_o = stall_q;
    assign busy_o      = busy_q;

    // The snapshot is only ever taken while no readout is in flight.
    a_snap_idle_only: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        ev.load |-> !busy_q)
        else $error("snapshot taken during a readout");

    // A short counter steps modulo 2**20, so all ones rolls to zero. Every step is
    // checked because no run is long enough to climb to the top of the range.
    a_short_wrap: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        ev.rx_inc[RX_CRC]
        |=> rx_cnt_q[RX_CRC] == {12'h000, $past(rx_cnt_q[RX_CRC][19:0]) + 20'h00001})
        else $error("short receive counter left its 20-bit range");

    // The wide good counter steps by exactly one per good frame.
    a_rx_good_step: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        ev.rx_inc[RX_GOOD] |=> rx_cnt_q[RX_GOOD] == $past(rx_cnt_q[RX_GOOD]) + 32'h1)
        else $error("good receive counter did not advance by one");

    // A readout in flight leaves an idle drop counter untouched.
    a_read_keeps: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        busy_q && !ev.rx_inc[RX_DROP] |=> rx_cnt_q[RX_DROP] == $past(rx_cnt_q[RX_DROP]))
        else $error("counter changed by a readout");

    // A dropped frame never reaches the bad or CRC counters.
    a_drop_only: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        rx_stat_vld_i && rx_fifo_drop_i
        |-> ev.rx_inc[RX_DROP] && !ev.rx_inc[RX_BAD] && !ev.rx_inc[RX_CRC])
        else $error("dropped frame reached an error counter");

    // Pause frames go to their own counter and never to the good one.
    a_pause_apart: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        ev.tx_inc[TX_PAUSE] |-> !ev.tx_inc[TX_GOOD] && tx_pause_i)
        else $error("pause frame counted as good");

    // Wrong selector or length is stalled and starts nothing.
    a_bad_len_stall: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        refuse |=> rsp_stall_o && !busy_o && !rsp_vld_o)
        else $error("malformed request not stalled");

    // The first word appears three cycles after the request is taken.
    a_first_word: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        take |-> !rsp_vld_o ##1 !rsp_vld_o ##1 !rsp_vld_o ##1 rsp_vld_o)
        else $error("first readout word late or early");

    // A transmit request walks twelve words, a receive request ten.
    a_set_length: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        take |=> last_q == (($past(req_index_i) == SEL_TX) ? TX_LAST : RX_LAST))
        else $error("readout length does not match the selected set");

    // An offered word holds still until it is taken.
    a_word_holds: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        rsp_vld_o && !rsp_ready_i |=> rsp_vld_o && $stable(rsp_data_o) && $stable(rsp_last_o))
        else $error("readout word changed before acceptance");

    // Carrier trouble always counts the frame as bad as well.
    a_carrier_bad: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        ev.tx_inc[TX_CARR] |-> ev.tx_inc[TX_BAD] && !ev.tx_inc[TX_GOOD])
        else $error("carrier error not counted as bad frame");

    // The pause counter steps inside its 20 bits and wraps there.
    a_pause_step: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        ev.tx_inc[TX_PAUSE]
        |=> tx_cnt_q[TX_PAUSE] == {12'h000, $past(tx_cnt_q[TX_PAUSE][19:0]) + 20'h00001})
        else $error("pause counter did not step within 20 bits");

    // Any kept frame with a CRC, late collision or PHY error is counted bad and never good.
    a_rx_bad_total: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        rx_stat_vld_i && !rx_fifo_drop_i && (rx_crc_err_i || rx_late_col_i || rx_phy_err_i)
        |-> ev.rx_inc[RX_BAD] && !ev.rx_inc[RX_GOOD])
        else $error("errored frame not counted as bad");

    // The last flag only rides on the final word of the selected set.
    a_last_word: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        rsp_last_o |-> rsp_vld_o && ptr_q == last_q)
        else $error("last flag on a word that is not the final one");

    // A request during a readout is ignored: no stall and no new set length.
    // The host must wait for busy_o to fall; a restart here would tear the snapshot.
    a_busy_ignores: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        req_vld_i && busy_q |=> !rsp_stall_o && $stable(last_q))
        else $error("request during a readout was acted upon");

endmodule

// ---- core/stats_event_decode.sv ----
/*
 * Turns one receive or transmit status event into per-counter increment
 * strobes. Assumes the status inputs come from logic on the same clock and
 * that each valid strobe lasts one cycle per frame.
 */
module stats_event_decode
    import stats_pkg::*;
#(
    parameter int LEN_W = 14
) (
    // Receive status.
    input  wire logic             rx_stat_vld_i,
    input  wire logic             rx_crc_err_i,
    input  wire logic             rx_dribble_i,
    input  wire logic             rx_late_col_i,
    input  wire logic             rx_phy_err_i,
    input  wire logic             rx_fifo_drop_i,
    input  wire logic [LEN_W-1:0] rx_len_i,
    input  wire logic [LEN_W-1:0] max_len_i,
    // Transmit status.
    input  wire logic             tx_stat_vld_i,
    input  wire logic             tx_pause_i,
    input  wire logic [4:0]       tx_col_cnt_i,
    input  wire logic             tx_excess_col_i,
    input  wire logic             tx_late_col_i,
    input  wire logic             tx_underrun_i,
    input  wire logic             tx_excess_defer_i,
    input  wire logic             tx_carrier_err_i,
    // Increment strobes.
    stats_if.dec                  ev
);
    logic rx_long, rx_err, rx_cnt_err, tx_abort, tx_err, tx_ok;

    // A frame dropped for lack of room reaches the drop counter and, when error-free, the good counter too.
    assign rx_long    = rx_len_i > max_len_i;
    assign rx_err     = rx_crc_err_i | rx_long | rx_late_col_i | rx_phy_err_i;
    assign rx_cnt_err = rx_stat_vld_i & ~rx_fifo_drop_i;
    assign ev.rx_inc[RX_GOOD]  = rx_stat_vld_i & ~rx_err;
    assign ev.rx_inc[RX_CRC]   = rx_cnt_err & rx_crc_err_i & ~rx_dribble_i;
    assign ev.rx_inc[RX_RUNT]  = rx_cnt_err & rx_crc_err_i
                                 & (rx_len_i < LEN_W'(RUNT_BYTES));
    assign ev.rx_inc[RX_ALIGN] = rx_cnt_err & rx_crc_err_i & rx_dribble_i;
    assign ev.rx_inc[RX_LONG]  = rx_cnt_err & rx_long;
    assign ev.rx_inc[RX_LATE]  = rx_cnt_err & rx_late_col_i;
    assign ev.rx_inc[RX_BAD]   = rx_cnt_err & rx_err;
    assign ev.rx_inc[RX_DROP]  = rx_stat_vld_i & rx_fifo_drop_i;

    // Carrier trouble spoils a frame like any abort does.
    assign tx_abort = tx_excess_col_i | tx_late_col_i | tx_underrun_i | tx_excess_defer_i;
    assign tx_err   = tx_abort | tx_carrier_err_i;
    assign tx_ok    = tx_stat_vld_i & ~tx_err;
    assign ev.tx_inc[TX_GOOD]   = tx_ok & ~tx_pause_i;
    assign ev.tx_inc[TX_PAUSE]  = tx_ok & tx_pause_i;
    assign ev.tx_inc[TX_SINGLE] = tx_ok & (tx_col_cnt_i == 5'h01);
    assign ev.tx_inc[TX_MULTI]  = tx_ok & (tx_col_cnt_i > 5'h01);
    assign ev.tx_inc[TX_XCOL]   = tx_stat_vld_i & tx_excess_col_i;
    assign ev.tx_inc[TX_LATE]   = tx_stat_vld_i & tx_late_col_i;
    assign ev.tx_inc[TX_UNDER]  = tx_stat_vld_i & tx_underrun_i;
    assign ev.tx_inc[TX_DEFER]  = tx_stat_vld_i & tx_excess_defer_i;
    assign ev.tx_inc[TX_CARR]   = tx_stat_vld_i & tx_carrier_err_i;
    assign ev.tx_inc[TX_BAD]    = tx_stat_vld_i & tx_err;
endmodule

// ---- core/stats_if.sv ----
/*
 * Internal carrier between the statistics top, its event decoder and its
 * snapshot memory. Assumes all three run on the same clock.
 */
interface stats_if;
    import stats_pkg::*;

    logic                    rx_inc [RX_CNTS];
    logic                    tx_inc [TX_CNTS];
    logic                    load;
    logic [CNT_W-1:0]        load_data [SNAP_WORDS];
    logic                    rd_en;
    logic [PTR_W-1:0]        rd_addr;
    logic [CNT_W-1:0]        rd_data;

    modport dec (output rx_inc, tx_inc);
    modport cnt (input rx_inc, tx_inc, rd_data, output load, load_data, rd_en, rd_addr);
    modport mem (input load, load_data, rd_en, rd_addr, output rd_data);
endinterface

// ---- core/stats_pkg.sv ----
/*
 * Shared constants for the frame statistics block: counter slots, word
 * counts, readout selector codes, transfer lengths and the readout states.
 * Assumes every user imports the whole package.
 */
package stats_pkg;

    // Counter slots of the receive set, in readout order.
    localparam int RX_GOOD = 0, RX_CRC = 1, RX_RUNT = 2, RX_ALIGN = 3,
                   RX_LONG = 4, RX_LATE = 5, RX_BAD = 6, RX_DROP = 7;
    localparam int RX_CNTS = 8;

    // Counter slots of the transmit set, in readout order.
    localparam int TX_GOOD = 0, TX_PAUSE = 1, TX_SINGLE = 2, TX_MULTI = 3,
                   TX_XCOL = 4, TX_LATE = 5, TX_UNDER = 6, TX_DEFER = 7,
                   TX_CARR = 8, TX_BAD = 9;
    localparam int TX_CNTS = 10;

    // Counter widths; slots not marked wide wrap at the short width.
    localparam int CNT_W   = 32;
    localparam int SHORT_W = 20;
    localparam logic [RX_CNTS-1:0] RX_WIDE = 8'h01;
    localparam logic [TX_CNTS-1:0] TX_WIDE = 10'h001;

    // Readout geometry: words per set and the snapshot depth.
    localparam int SNAP_WORDS = 12;
    localparam int PTR_W      = 4;
    localparam logic [PTR_W-1:0] RX_LAST = 4'h9;
    localparam logic [PTR_W-1:0] TX_LAST = 4'hb;

    // Readout request selector codes and expected byte lengths.
    localparam logic [15:0] SEL_RX = 16'h0000;
    localparam logic [15:0] SEL_TX = 16'h0001;
    localparam logic [15:0] LEN_RX = 16'h0028;
    localparam logic [15:0] LEN_TX = 16'h0030;

    // Shortest legal frame in bytes.
    localparam int RUNT_BYTES = 64;

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SHOW, ST_SEND} rd_state_e;

endpackage

// ---- core/stats_snap_mem.sv ----
/*
 * Snapshot store for one counter set. All words load in a single edge so the
 * copy is consistent; reads come out of a register one cycle after rd_en.
 * Assumes one clock and a synchronous active-high reset.
 */
module stats_snap_mem
    import stats_pkg::*;
(
    // Clock and reset.
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    // Load and read port.
    stats_if.mem      sm
);
    logic [CNT_W-1:0] mem_q [SNAP_WORDS];
    logic [CNT_W-1:0] rd_q;

    // Whole-set load; a read in the same cycle sees the old contents.
    always_ff @(posedge ref_clk_i) begin
        if (sm.load) begin
            mem_q <= sm.load_data;
        end
        if (srst_i) begin
            rd_q <= '0;
        end else if (sm.rd_en) begin
            rd_q <= mem_q[sm.rd_addr];
        end
    end

    assign sm.rd_data = rd_q;
endmodule

// ---- dv/stats_counters_tb.sv ----
/*
 * Self-checking bench for the frame statistics counters.
 * Assumes the reader model in stats_reader.sv and one 250 MHz clock.
 */
module stats_counters_tb;
    import stats_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0, srst_i = 1'b1, rsp_ready_i;
    logic rx_stat_vld_i = 0, rx_crc_err_i = 0, rx_dribble_i = 0, rx_late_col_i = 0;
    logic rx_phy_err_i = 0, rx_fifo_drop_i = 0, tx_stat_vld_i = 0, tx_pause_i = 0;
    logic tx_excess_col_i = 0, tx_late_col_i = 0, tx_underrun_i = 0;
    logic tx_excess_defer_i = 0, tx_carrier_err_i = 0, req_vld_i = 0;
    logic [13:0] rx_len_i = 14'h0040, max_len_i = 14'h05ee;
    logic [4:0]  tx_col_cnt_i = 5'h00;
    logic [15:0] req_index_i = 16'h0000, req_length_i = 16'h0000;
    logic        rsp_vld_o, rsp_last_o, rsp_stall_o, busy_o;
    logic [31:0] rsp_data_o;
    logic [3:0]  slow = 4'h0;
    int          erx [12] = '{default: 0};
    int          etx [12] = '{default: 0};
    int          num_errors = 0, tests_run = 0, k;

    // Free-running 4 ns clock.
    always #2 ref_clk_i = ~ref_clk_i;

    stats_counters stats_counters_inst (.ref_clk_i, .srst_i, .rx_stat_vld_i, .rx_crc_err_i,
        .rx_dribble_i, .rx_late_col_i, .rx_phy_err_i, .rx_fifo_drop_i, .rx_len_i, .max_len_i,
        .tx_stat_vld_i, .tx_pause_i, .tx_col_cnt_i, .tx_excess_col_i, .tx_late_col_i,
        .tx_underrun_i, .tx_excess_defer_i, .tx_carrier_err_i, .req_vld_i, .req_index_i,
        .req_length_i, .rsp_ready_i, .rsp_vld_o, .rsp_data_o, .rsp_last_o, .rsp_stall_o,
        .busy_o);
    stats_reader stats_reader_inst (.ref_clk_i, .vld_i(rsp_vld_o), .data_i(rsp_data_o),
        .last_i(rsp_last_o), .slow_i(slow), .ready_o(rsp_ready_i));

    task automatic results;
        if (num_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One receive frame; f is {crc, dribble, late, phy, drop}.
    task automatic rx_ev(input logic [4:0] f, input logic [13:0] len);
        logic bad;
        bad = f[4] | (len > max_len_i) | f[2] | f[1];
        @(posedge ref_clk_i); #1;
        {rx_crc_err_i, rx_dribble_i, rx_late_col_i, rx_phy_err_i, rx_fifo_drop_i} = f;
        rx_len_i = len;
        rx_stat_vld_i = 1'b1;
        @(posedge ref_clk_i); #1;
        rx_stat_vld_i = 1'b0;
        if (!bad) erx[0]++;
        if (f[0]) erx[7]++;
        if (!f[0]) begin
            erx[1] += f[4] & !f[3];
            erx[2] += f[4] & (len < 14'd64);
            erx[3] += f[4] & f[3];
            erx[4] += (len > max_len_i);
            erx[5] += f[2];
            erx[6] += bad;
        end
    endtask

    // One transmit outcome; f is {pause, xcol, late, underrun, defer, carrier}.
    task automatic tx_ev(input logic [5:0] f, input logic [4:0] col);
        logic err;
        err = |f[4:0];
        @(posedge ref_clk_i); #1;
        {tx_pause_i, tx_excess_col_i, tx_late_col_i, tx_underrun_i, tx_excess_defer_i,
            tx_carrier_err_i} = f;
        tx_col_cnt_i = col;
        tx_stat_vld_i = 1'b1;
        @(posedge ref_clk_i); #1;
        tx_stat_vld_i = 1'b0;
        etx[0] += !err & !f[5];
        etx[1] += !err & f[5];
        etx[2] += !err & (col == 5'd1);
        etx[3] += !err & (col > 5'd1);
        for (int j = 0; j < 5; j++) etx[4 + j] += f[4 - j];
        etx[9] += err;
    endtask

    // Full readout; expectations are frozen at the request, as the snapshot is.
    // A poke re-sends the request that many cycles in, while busy, to show it is ignored.
    task automatic read_set(input logic [15:0] idx, input logic [15:0] len, input int n,
                            input int poke = -1);
        logic [31:0] e [12];
        int i;
        for (i = 0; i < 12; i++) e[i] = idx[0] ? etx[i] : erx[i];
        stats_reader_inst.count = 0;
        stats_reader_inst.last_at = -1;
        @(posedge ref_clk_i); #1;
        req_vld_i = 1'b1;
        req_index_i = idx;
        req_length_i = len;
        @(posedge ref_clk_i); #1;
        req_vld_i = 1'b0;
        check("busy", 32'h1, {31'h0, busy_o});
        i = 0;
        while ((busy_o !== 1'b0 || stats_reader_inst.count < n) && i < 400) begin
            @(posedge ref_clk_i); #1;
            req_vld_i = (i == poke);
            i++;
        end
        if (i == 400) begin
            num_errors++;
            results();
        end
        check("words", n, stats_reader_inst.count);
        check("last", n - 1, stats_reader_inst.last_at);
        for (i = 0; i < n; i++) check("word", e[i], stats_reader_inst.words[i]);
    endtask

    // A bad selector or length must give exactly one stall pulse and no readout.
    task automatic refuse(input logic [15:0] idx, input logic [15:0] len);
        int s;
        s = 0;
        @(posedge ref_clk_i); #1;
        req_vld_i = 1'b1;
        req_index_i = idx;
        req_length_i = len;
        @(posedge ref_clk_i); #1;
        req_vld_i = 1'b0;
        for (int j = 0; j < 4; j++) begin
            if (rsp_stall_o === 1'b1) s++;
            if (busy_o !== 1'b0 || rsp_vld_o !== 1'b0) s += 10;
            @(posedge ref_clk_i); #1;
        end
        check("stall", 32'h1, s);
    endtask

    // Main sequence.
    initial begin
        repeat (10) @(posedge ref_clk_i);
        #1;
        srst_i = 1'b0;
        read_set(SEL_RX, LEN_RX, 10);
        read_set(SEL_TX, LEN_TX, 12);
        rx_ev(5'h00, 14'd100);
        rx_ev(5'h10, 14'd100);
        rx_ev(5'h18, 14'd100);
        rx_ev(5'h10, 14'd63);
        rx_ev(5'h10, 14'd64);
        rx_ev(5'h00, 14'h05ef);
        rx_ev(5'h00, 14'h05ee);
        rx_ev(5'h04, 14'd100);
        rx_ev(5'h02, 14'd100);
        rx_ev(5'h11, 14'd100);
        rx_ev(5'h01, 14'd100);
        read_set(SEL_RX, LEN_RX, 10);
        tx_ev(6'h00, 5'd0);
        tx_ev(6'h20, 5'd0);
        tx_ev(6'h00, 5'd1);
        tx_ev(6'h00, 5'd2);
        for (k = 0; k < 5; k++) tx_ev(6'h01 << k, 5'd0);
        slow = 4'h3;
        read_set(SEL_TX, LEN_TX, 12, 3);
        refuse(16'h0002, LEN_RX);
        refuse(SEL_RX, LEN_TX);
        refuse(SEL_TX, LEN_RX);
        fork
            read_set(SEL_RX, LEN_RX, 10);
            begin
                repeat (8) @(posedge ref_clk_i);
                rx_ev(5'h00, 14'd100);
            end
        join
        slow = 4'h0;
        read_set(SEL_RX, LEN_RX, 10);
        results();
    end
endmodule

// ---- dv/stats_reader.sv ----
/*
 * Partner model: the control-request reader that drains readout words.
 * Assumes words are offered on ref_clk_i and held until they are taken.
 */
module stats_reader (
    // Clock and offered word.
    input  wire logic        ref_clk_i,
    input  wire logic        vld_i,
    input  wire logic [31:0] data_i,
    input  wire logic        last_i,
    // Pacing and acceptance.
    input  wire logic [3:0]  slow_i,
    output logic             ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] words [12];
    int          count = 0;
    int          last_at = -1;
    int          wait_n = 0;
    initial ready_o = 1'b0;
    // A slow host waits slow_i cycles per word, so held words get exercised.
    always @(posedge ref_clk_i) begin
        if (vld_i && ready_o) begin
            words[count % 12] = data_i;
            if (last_i) last_at = count;
            count++;
            wait_n = 0;
            ready_o <= #1 1'b0;
        end else if (vld_i) begin
            if (wait_n >= slow_i) ready_o <= #1 1'b1;
            wait_n++;
        end
    end
endmodule
